// ---- rtl/pic_port_config.v ----
// Indirectly addressed pin configuration sub-registers of one general-purpose port.
//
// Overview of operation
// - Selector 06H in the address register routes control accesses to pull-up enables.
// - Each pull-up bit enables its pin's weak pull-up; all bits reset to zero.
// - A recovery-enabled pin toggling during stop mode starts stop mode recovery.
// - A pin with recovery disabled never starts recovery by toggling.
// - Selector 07H routes control accesses to the alternate function set 1 register.
// - Set 1 bits choose which alternate function each pin carries.
// - The set 1 choice only applies while the pin's alternate enable is set.
`timescale 1ns/1ps
`include "pic_regs.vh"
module pic_port_config #(
   parameter PINS = `PIC_PIN_COUNT
) (
   // Clock, reset and clock enable.
   input  wire            sys_clk_in,
   input  wire            reset_in,
   input  wire            clk_en_in,
   // Port address register access.
   input  wire            addr_wr_in,
   // Port control register access.
   input  wire            ctrl_wr_in,
   input  wire [7:0]      wdata_in,
   output reg  [7:0]      addr_rdata_out,
   output reg  [7:0]      ctrl_rdata_out,
   // Pins and power state.
   input  wire [PINS-1:0] pin_in,
   input  wire            stop_mode_in,
   // Configuration results.
   output reg  [PINS-1:0] pin_pullup_enable_out,
   output reg             stop_recovery_out,
   output wire [PINS-1:0] alt_sel1_out,
   output wire [PINS-1:0] alt_sel0_out
);
   // Selector and sub-register storage.
   reg  [7:0]      port_addr_reg;
   reg  [7:0]      port_pullup_enable_reg;
   reg  [7:0]      stop_recovery_source_enable_reg;
   reg  [7:0]      alt_set1_reg;
   reg  [7:0]      alt_enable_reg;

   // Read path and per-pin results.
   reg  [7:0]      ctrl_rdata_next;
   wire [PINS-1:0] wake;

   // Selector decode and write strobes.
   wire            sel_pullup;
   wire            sel_alt_set1;
   wire            sel_recovery;
   wire            sel_alt_enable;
   wire            wr_pullup;
   wire            wr_alt_set1;
   wire            wr_recovery;
   wire            wr_alt_enable;

   // Decode the selector that stands in the address register before this edge.
   // Any other selector value matches nothing, so control writes to it are dropped.
   // Only the four mapped codes below reach a sub-register.
   // The decode is shared by the write strobes and reads the same register as the read mux.
   assign sel_pullup     = (port_addr_reg == `PIC_SEL_PULLUP);
   assign sel_alt_set1   = (port_addr_reg == `PIC_SEL_ALT_SET1);
   assign sel_recovery   = (port_addr_reg == `PIC_SEL_STOP_RECOVERY);
   assign sel_alt_enable = (port_addr_reg == `PIC_SEL_ALT_ENABLE);

   // Qualify control writes with the decoded selector.
   // An address write on the same edge only steers the next access, never this one.
   // This keeps the order of two writes on one edge free of any race.
   assign wr_pullup     = ctrl_wr_in & sel_pullup;
   assign wr_alt_set1   = ctrl_wr_in & sel_alt_set1;
   assign wr_recovery   = ctrl_wr_in & sel_recovery;
   assign wr_alt_enable = ctrl_wr_in & sel_alt_enable;

   // Port address register, loaded by address writes only.
   // A control write never touches it, so back-to-back and same-edge writes are safe.
   // Its value is kept while the clock enable is low.
   always @(posedge sys_clk_in) begin
      if (reset_in) begin
         port_addr_reg <= `PIC_RST_ADDR;
      end else if (clk_en_in) begin
         if (addr_wr_in) begin
            port_addr_reg <= wdata_in;
         end
      end
   end

   // Pull-up enable sub-register, one bit per pin.
   // It clears on reset so no pin is pulled up until software asks for it.
   // A write replaces all eight bits at once.
   always @(posedge sys_clk_in) begin
      if (reset_in) begin
         port_pullup_enable_reg <= `PIC_RST_PULLUP;
      end else if (clk_en_in) begin
         if (wr_pullup) begin
            port_pullup_enable_reg <= wdata_in;
         end
      end
   end

   // Stop recovery source enable sub-register.
   // It clears on reset, so no pin can end stop mode until software enables it.
   // Each bit feeds the transition detector of its own pin slice.
   always @(posedge sys_clk_in) begin
      if (reset_in) begin
         stop_recovery_source_enable_reg <= `PIC_RST_STOP_RECOVERY;
      end else if (clk_en_in) begin
         if (wr_recovery) begin
            stop_recovery_source_enable_reg <= wdata_in;
         end
      end
   end

   // Alternate function set 1 sub-register.
   // Its bits only steer pins whose alternate enable is also set.
   // Software may load it before enabling the pins to avoid a wrong function for a cycle.
   always @(posedge sys_clk_in) begin
      if (reset_in) begin
         alt_set1_reg <= `PIC_RST_ALT_SET1;
      end else if (clk_en_in) begin
         if (wr_alt_set1) begin
            alt_set1_reg <= wdata_in;
         end
      end
   end

   // Alternate function enable sub-register.
   // Clear bits keep their pins on plain port use whatever set 1 holds.
   // It is the gate that lets a set 1 choice reach a pin.
   always @(posedge sys_clk_in) begin
      if (reset_in) begin
         alt_enable_reg <= `PIC_RST_ALT_ENABLE;
      end else if (clk_en_in) begin
         if (wr_alt_enable) begin
            alt_enable_reg <= wdata_in;
         end
      end
   end

   // Read mux of the selected sub-register.
   // Unknown selectors read zero, so stale data never leaks through the control register.
   // The mux follows the selector directly, so a new selector shows one cycle later.
   // Every branch assigns the result, which keeps the process free of latches.
   always @* begin
      case (port_addr_reg)
         `PIC_SEL_PULLUP: begin
            ctrl_rdata_next = port_pullup_enable_reg;
         end
         `PIC_SEL_ALT_SET1: begin
            ctrl_rdata_next = alt_set1_reg;
         end
         `PIC_SEL_STOP_RECOVERY: begin
            ctrl_rdata_next = stop_recovery_source_enable_reg;
         end
         `PIC_SEL_ALT_ENABLE: begin
            ctrl_rdata_next = alt_enable_reg;
         end
         default: begin
            ctrl_rdata_next = 8'h00;
         end
      endcase
   end

   // Registered read data of both registers.
   // Reads see the register contents one cycle after they change.
   // The address register reads back as written, whether mapped or not.
   // Both outputs freeze with the rest of the block while the clock enable is low.
   always @(posedge sys_clk_in) begin
      if (reset_in) begin
         addr_rdata_out <= 8'h00;
         ctrl_rdata_out <= 8'h00;
      end else if (clk_en_in) begin
         addr_rdata_out <= port_addr_reg;
         ctrl_rdata_out <= ctrl_rdata_next;
      end
   end

   // Registered pull-up controls; bit n goes to pin n.
   // The flop keeps the pad controls free of glitches from the write path.
   // They lag the sub-register by one cycle.
   // All pull-ups are off during and right after reset.
   always @(posedge sys_clk_in) begin
      if (reset_in) begin
         pin_pullup_enable_out <= {PINS{1'b0}};
      end else if (clk_en_in) begin
         pin_pullup_enable_out <= port_pullup_enable_reg[PINS-1:0];
      end
   end

   // Stop recovery request, two cycles after an enabled pin toggled in stop mode.
   // The per-pin results merge here so the request leaves the block from one flop.
   // Pins with recovery disabled never set their slice result, so they cannot raise it.
   // The request is a one-cycle pulse per detected transition.
   always @(posedge sys_clk_in) begin
      if (reset_in) begin
         stop_recovery_out <= 1'b0;
      end else if (clk_en_in) begin
         stop_recovery_out <= |wake;
      end
   end

   // One slice per pin; bit n of each register drives pin n.
   // Each slice keeps its own pin history and alternate function flops.
   // The slices share the clock, reset, clock enable and stop state.
   genvar n;
   generate
      for (n = 0; n < PINS; n = n + 1) begin : g_pin
         pic_pin_slice u_slice (
            .sys_clk_in     (sys_clk_in),
            .reset_in       (reset_in),
            .clk_en_in      (clk_en_in),
            .stop_mode_in   (stop_mode_in),
            .pin_in         (pin_in[n]),
            .recovery_en_in (stop_recovery_source_enable_reg[n]),
            .alt_enable_in  (alt_enable_reg[n]),
            .alt_set1_in    (alt_set1_reg[n]),
            .wake_out       (wake[n]),
            .alt_sel1_out   (alt_sel1_out[n]),
            .alt_sel0_out   (alt_sel0_out[n])
         );
      end
   endgenerate
endmodule

// ---- rtl/pic_regs.vh ----
// Selector codes, reset values and pin count of the indirect pin configuration block.
`ifndef PIC_REGS_VH
`define PIC_REGS_VH
`define PIC_SEL_STOP_RECOVERY  8'h05
`define PIC_SEL_PULLUP         8'h06
`define PIC_SEL_ALT_SET1       8'h07
`define PIC_SEL_ALT_ENABLE     8'h02
`define PIC_RST_STOP_RECOVERY  8'h00
`define PIC_RST_PULLUP         8'h00
`define PIC_RST_ALT_SET1       8'h00
`define PIC_RST_ALT_ENABLE     8'h00
`define PIC_RST_ADDR           8'h00
`define PIC_PIN_COUNT          8
`endif

// ---- rtl/pic_pin_slice.v ----
// Per-pin slice: transition detect for stop recovery and alternate function routing.
`timescale 1ns/1ps
module pic_pin_slice (
   // Clock and control.
   input  wire sys_clk_in,
   input  wire reset_in,
   input  wire clk_en_in,
   input  wire stop_mode_in,
   // Pin and configuration.
   input  wire pin_in,
   input  wire recovery_en_in,
   input  wire alt_enable_in,
   input  wire alt_set1_in,
   // Results.
   output reg  wake_out,
   output reg  alt_sel1_out,
   output reg  alt_sel0_out
);
   reg pin_last_reg;

   // Remember the previous pin level and flag a qualified transition in stop mode.
   always @(posedge sys_clk_in) begin
      if (reset_in) begin
         pin_last_reg <= 1'b0;
         wake_out     <= 1'b0;
         alt_sel1_out <= 1'b0;
         alt_sel0_out <= 1'b0;
      end else if (clk_en_in) begin
         pin_last_reg <= pin_in;
         // Only enabled pins may start recovery; others are ignored.
         wake_out     <= stop_mode_in & recovery_en_in & (pin_in ^ pin_last_reg);
         // Set 1 choice only routes when the pin's alternate enable is set.
         alt_sel1_out <= alt_enable_in & alt_set1_in;
         alt_sel0_out <= alt_enable_in & ~alt_set1_in;
      end
   end
endmodule

// ---- dv/pic_port_config_checker.sv ----
// Port assertions for the indirect pin configuration block.
`timescale 1ns/1ps
module pic_port_config_checker #(parameter PINS = 8) (
   // All ports of the block, watched only.
   input wire            sys_clk_in, reset_in, clk_en_in, addr_wr_in, ctrl_wr_in,
   input wire [7:0]      wdata_in, addr_rdata_out, ctrl_rdata_out,
   input wire [PINS-1:0] pin_in, pin_pullup_enable_out, alt_sel1_out, alt_sel0_out,
   input wire            stop_mode_in, stop_recovery_out
);
   reg  [7:0]      sel_q;
   reg  [PINS-1:0] rec_q, aen_q, as1_q, pin_q;
   wire            pu_wr = clk_en_in && ctrl_wr_in && sel_q == 8'h06;
   wire            cause = stop_mode_in && |((pin_in ^ pin_q) & rec_q);
   // Shadow copies of the selector, the gating registers and the pin history.
   always @(posedge sys_clk_in) begin
      if (reset_in) begin
         {sel_q, rec_q, aen_q, as1_q, pin_q} <= '0;
      end else if (clk_en_in) begin
         pin_q <= pin_in;
         if (addr_wr_in) sel_q <= wdata_in;
         if (ctrl_wr_in && sel_q == 8'h05) rec_q <= wdata_in[PINS-1:0];
         if (ctrl_wr_in && sel_q == 8'h02) aen_q <= wdata_in[PINS-1:0];
         if (ctrl_wr_in && sel_q == 8'h07) as1_q <= wdata_in[PINS-1:0];
      end
   end
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (reset_in);
   sequence s_pu_wr; pu_wr ##1 clk_en_in; endsequence
   sequence s_unmapped; clk_en_in && sel_q == 8'h0A ##1 clk_en_in && sel_q == 8'h0A; endsequence
   sequence s_toggle; clk_en_in && cause ##1 clk_en_in; endsequence
   a_pullup_write: assert property (s_pu_wr |=> pin_pullup_enable_out == $past(wdata_in, 2))
      else $error("pull-up enables differ from written value");
   a_pullup_reset: assert property ($fell(reset_in) |-> pin_pullup_enable_out == 0)
      else $error("pull-up enables not cleared by reset");
   a_pullup_hold: assert property ($changed(pin_pullup_enable_out) |-> $past(pu_wr, 2))
      else $error("pull-up enables changed without a write");
   a_recovery_wake: assert property (s_toggle |=> stop_recovery_out)
      else $error("enabled pin toggle in stop gave no recovery");
   a_recovery_masked: assert property ($rose(stop_recovery_out) |-> $past(cause, 2))
      else $error("recovery started without an enabled toggle");
   a_alt_set1: assert property ($past(clk_en_in) |-> alt_sel1_out == $past(aen_q & as1_q))
      else $error("set 1 selection wrong");
   a_alt_gate: assert property ($past(clk_en_in) |-> alt_sel0_out == $past(aen_q & ~as1_q))
      else $error("alternate selection not gated by enable");
   a_unmapped_read: assert property (s_unmapped |=> ctrl_rdata_out == 8'h00)
      else $error("unmapped selector read not zero");
endmodule
bind pic_port_config pic_port_config_checker #(.PINS(PINS)) chk (.*);

// ---- dv/test_pic_port_config.sv ----
// Self-checking bench for the indirect pin configuration block.
`timescale 1ns/1ps
module test_pic_port_config;
   reg        sys_clk_in = 0, reset_in = 1, clk_en_in = 1, addr_wr_in = 0, ctrl_wr_in = 0;
   reg        stop_mode_in = 0;
   reg  [7:0] wdata_in = 8'h00, pin_in = 8'h00;
   wire [7:0] addr_rdata_out, ctrl_rdata_out, pin_pullup_enable_out, alt_sel1_out, alt_sel0_out;
   wire       stop_recovery_out;
   integer    miscompares = 0, check_count = 0, cycles = 0;
   pic_port_config dut (
      .sys_clk_in            (sys_clk_in),
      .reset_in              (reset_in),
      .clk_en_in             (clk_en_in),
      .addr_wr_in            (addr_wr_in),
      .ctrl_wr_in            (ctrl_wr_in),
      .wdata_in              (wdata_in),
      .addr_rdata_out        (addr_rdata_out),
      .ctrl_rdata_out        (ctrl_rdata_out),
      .pin_in                (pin_in),
      .stop_mode_in          (stop_mode_in),
      .pin_pullup_enable_out (pin_pullup_enable_out),
      .stop_recovery_out     (stop_recovery_out),
      .alt_sel1_out          (alt_sel1_out),
      .alt_sel0_out          (alt_sel0_out)
   );
   // A 100 ns clock and a cycle ceiling that cuts a hang short.
   always #50 sys_clk_in = ~sys_clk_in;
   always @(posedge sys_clk_in) begin
      cycles = cycles + 1;
      if (cycles == 2000) begin
         miscompares = miscompares + 1;
         wrap_up;
      end
   end
   // Wait n rising edges, then move just past the last one.
   task step(input integer n);
      begin
         repeat (n) @(posedge sys_clk_in);
         #1;
      end
   endtask
   // One write: a=1 to the address register, a=0 to the selected sub-register.
   // The strobes are released for one idle edge, so back-to-back calls never overlap.
   task wr(input a, input [7:0] v);
      begin
         addr_wr_in = a;
         ctrl_wr_in = !a;
         wdata_in = v;
         step(1);
         addr_wr_in = 0;
         ctrl_wr_in = 0;
         step(1);
      end
   endtask
   task chk(input string nm, input [7:0] seen, input [7:0] exp);
      begin
         check_count = check_count + 1;
         if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask
   task wrap_up;
      begin
         $display("checks %0d mismatches %0d", check_count, miscompares);
         if (miscompares == 0 && check_count > 0) $display("ALL TESTS PASSED");
         else $display("TESTS FAILED");
         $finish;
      end
   endtask
   // Main sequence of tests.
   initial begin
      step(4);
      reset_in = 0;
      step(1);
      chk("pullup", pin_pullup_enable_out, 8'h00);
      wr(1, 8'h06);
      wr(0, 8'hA5);
      step(2);
      chk("pullup", pin_pullup_enable_out, 8'hA5);
      chk("readback", ctrl_rdata_out, 8'hA5);
      chk("address", addr_rdata_out, 8'h06);
      $display("pull-up test done");
      wr(1, 8'h05);
      wr(0, 8'h01);
      stop_mode_in = 1;
      step(1);
      pin_in = 8'h02;
      step(2);
      chk("wake", {7'h0, stop_recovery_out}, 8'h00);
      pin_in = 8'h03;
      step(2);
      chk("wake", {7'h0, stop_recovery_out}, 8'h01);
      chk("recovery readback", ctrl_rdata_out, 8'h01);
      $display("stop recovery test done");
      wr(1, 8'h07);
      wr(0, 8'h0F);
      step(1);
      chk("set1 readback", ctrl_rdata_out, 8'h0F);
      wr(1, 8'h02);
      wr(0, 8'h3C);
      step(2);
      chk("alt1", alt_sel1_out, 8'h0C);
      chk("alt0", alt_sel0_out, 8'h30);
      chk("address", addr_rdata_out, 8'h02);
      $display("alternate function test done");
      wr(1, 8'h0A);
      wr(0, 8'hFF);
      step(3);
      chk("unmapped", ctrl_rdata_out, 8'h00);
      addr_wr_in = 1;
      ctrl_wr_in = 1;
      wdata_in = 8'h06;
      step(1);
      addr_wr_in = 0;
      ctrl_wr_in = 0;
      step(2);
      chk("same edge address", addr_rdata_out, 8'h06);
      chk("same edge pullup", pin_pullup_enable_out, 8'hA5);
      $display("unmapped selector test done");
      wr(1, 8'h06);
      clk_en_in = 0;
      wr(0, 8'h00);
      clk_en_in = 1;
      step(3);
      chk("frozen", pin_pullup_enable_out, 8'hA5);
      chk("frozen readback", ctrl_rdata_out, 8'hA5);
      $display("refusal test done");
      wrap_up;
   end
endmodule
